// >>> src/t1tx_cfg.svh
// timing, position and size constants for the t1 transmit pin block
`ifndef T1TX_CFG_SVH
`define T1TX_CFG_SVH

// ----------------------------------------------------------------
// clock rates
// ----------------------------------------------------------------
`define T1TX_SYS_CLK_HZ 20000000
`define T1TX_PRIMARY_HZ 1544000
`define T1TX_BACKPLANE_HZ 2048000
// half periods in system clocks, rounded down
`define T1TX_PRIMARY_HALF_CYC (`T1TX_SYS_CLK_HZ / (2 * `T1TX_PRIMARY_HZ))
`define T1TX_BACKPLANE_HALF_CYC (`T1TX_SYS_CLK_HZ / (2 * `T1TX_BACKPLANE_HZ))

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define T1TX_LAST_BIT 8'd192
`define T1TX_D4_LAST_FRAME 5'd11
`define T1TX_ESF_LAST_FRAME 5'd23
`define T1TX_FS_PATTERN 6'h1c
`define T1TX_FPS_PATTERN 6'h34

// ----------------------------------------------------------------
// positions of synchronised pins in the input vector
// ----------------------------------------------------------------
`define T1TX_IN_TX_PRIMARY_CLOCK 0
`define T1TX_IN_RCLK 1
`define T1TX_IN_BCLK 2
`define T1TX_IN_LINK 3
`define T1TX_IN_SIG 4
`define T1TX_IN_DATA 5
`define T1TX_IN_SYSD 6
`define T1TX_IN_SYNC 7
`define T1TX_IN_SSYNC 8
`define T1TX_IN_LPOS 9
`define T1TX_IN_LNEG 10
`define T1TX_IN_LCLK 11
`define T1TX_IN_N 12

// ----------------------------------------------------------------
// elastic store
// ----------------------------------------------------------------
`define T1TX_ESTORE_WIDTH 1
`define T1TX_ESTORE_DEPTH 32

`endif

// >>> src/t1tx_pkg.sv
// types shared by both ends of the t1 transmit pin block
package t1tx_pkg;
  // ----------------------------------------------------------------
  // framing formats
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    T1TX_FM_D4 = 2'h0,
    T1TX_FM_ESF = 2'h1,
    T1TX_FM_ZBTSI = 2'h2
  } t1tx_frame_mode_t;

  // ----------------------------------------------------------------
  // device end state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] meta;
    logic [11:0] sync;
    logic fclk_reg;
    logic bclk_prev;
    logic lclk_prev;
    logic sync_prev;
    logic ssync_prev;
    logic sync_req;
    logic [7:0] bit_cnt;
    logic [4:0] frame_cnt;
    logic sig_bit;
    logic tx_bit;
    logic ami_last;
    logic pos_reg;
    logic neg_reg;
    logic estore_out_reg;
    logic sync_out_reg;
    logic sync_oe_reg;
    logic line_pos_reg;
    logic line_neg_reg;
  } t1tx_dev_state_t;

  // ----------------------------------------------------------------
  // host end state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] pdiv;
    logic [3:0] bdiv;
    logic pclk;
    logic bclk;
    logic [7:0] bit_cnt;
    logic link;
    logic sig;
    logic sysdata;
    logic sync_pulse;
    logic ssync_pulse;
    logic taken;
  } t1tx_host_state_t;
endpackage : t1tx_pkg

// >>> src/t1tx_if.sv
// pin bundle between the transmit device end and the backplane end
`timescale 1ns/1ps
interface t1tx_if;
  logic tx_primary_clock;
  logic recovered_clock_in;
  logic tx_backplane_clock;
  logic tx_link_data_in;
  logic tx_signaling_in;
  logic tx_data_in;
  logic tx_system_data_in;
  logic tx_system_sync_in;
  logic tx_estore_data_out;
  logic dev_sync_out;
  logic dev_sync_oe;
  logic host_sync_out;
  logic host_sync_oe;
  logic tx_sync_pin;
  logic formatter_pos_out;
  logic formatter_neg_out;
  logic formatter_clock_out;
  logic line_pos_in;
  logic line_neg_in;
  logic line_clock_in;
  logic line_iface_connect;

  // wire level of the shared sync pin, pulled low when nobody drives
  assign tx_sync_pin = dev_sync_oe ? dev_sync_out : (host_sync_oe ? host_sync_out : 1'b0);

  modport device (
    input tx_primary_clock, recovered_clock_in, tx_backplane_clock, tx_link_data_in,
    input tx_signaling_in, tx_data_in, tx_system_data_in, tx_system_sync_in,
    input tx_sync_pin, line_pos_in, line_neg_in, line_clock_in, line_iface_connect,
    output tx_estore_data_out, dev_sync_out, dev_sync_oe,
    output formatter_pos_out, formatter_neg_out, formatter_clock_out
  );
  modport host (
    output tx_primary_clock, recovered_clock_in, tx_backplane_clock, tx_link_data_in,
    output tx_signaling_in, tx_data_in, tx_system_data_in, tx_system_sync_in,
    output host_sync_out, host_sync_oe, line_pos_in, line_neg_in, line_clock_in,
    output line_iface_connect,
    input tx_sync_pin, tx_estore_data_out, formatter_pos_out, formatter_neg_out,
    input formatter_clock_out
  );
endinterface : t1tx_if

// >>> src/t1tx_fifo.sv
// elastic store fifo with valid/ready on both sides
`timescale 1ns/1ps
`include "t1tx_cfg.svh"
module t1tx_fifo #(
  parameter int WIDTH = `T1TX_ESTORE_WIDTH,
  parameter int DEPTH = `T1TX_ESTORE_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } t1tx_fifo_state_t;

  t1tx_fifo_state_t s;
  t1tx_fifo_state_t n;
  logic push;
  logic pop;

  // honest flags straight from the fill count
  assign in_ready = (s.count != (AW+1)'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data = s.mem[s.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer and count update; flush drops everything stored
  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wr] = in_data;
      n.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      n.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
    end
    n.count = s.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush) begin
      n.wr = '0;
      n.rd = '0;
      n.count = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : t1tx_fifo

// >>> src/t1tx_device.sv
// transmit formatter end: pin sampling, framing, line coding, line interface
`timescale 1ns/1ps
`include "t1tx_cfg.svh"
module t1tx_device
  import t1tx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  t1tx_if.device lnk,
  input wire logic link_insert_enable,
  input wire logic sync_output_select,
  input wire logic sync_multiframe_select,
  input wire logic sync_double_wide_enable,
  input wire logic output_nrz_select,
  input wire logic estore_enable,
  input wire logic signaling_insert_enable,
  input wire logic clock_source_recovered,
  input wire t1tx_frame_mode_t frame_mode,
  output logic line_pos_out,
  output logic line_neg_out,
  output logic estore_in_ready
);
  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // frames 6, 12, 18 and 24 carry robbed-bit signaling
  function automatic logic is_sig_frame(input logic [4:0] fr);
    is_sig_frame = (fr == 5'd5) || (fr == 5'd11) || (fr == 5'd17) || (fr == 5'd23);
  endfunction : is_sig_frame

  // patterns held as named vectors, since a literal cannot be bit-selected
  localparam logic [5:0] FS_PAT = `T1TX_FS_PATTERN;
  localparam logic [5:0] FPS_PAT = `T1TX_FPS_PATTERN;

  function automatic logic [4:0] last_frame(input t1tx_frame_mode_t fm);
    last_frame = (fm == T1TX_FM_D4) ? `T1TX_D4_LAST_FRAME : `T1TX_ESF_LAST_FRAME;
  endfunction : last_frame

  // ----------------------------------------------------------------
  // state and elastic store
  // ----------------------------------------------------------------
  t1tx_dev_state_t s;
  t1tx_dev_state_t n;
  logic [`T1TX_IN_N-1:0] pins;
  logic fclk;
  logic f_rise;
  logic f_fall;
  logic b_fall;
  logic lclk;
  logic l_fall;
  logic sync_edge;
  logic ssync_edge;
  logic push;
  logic push_bit;
  logic fifo_valid;
  logic fifo_data;
  logic link_slot;
  logic fbit;
  logic sig_src;
  logic [7:0] nb;
  logic [4:0] nf;
  logic sync_hi;

  assign pins = {lnk.line_clock_in, lnk.line_neg_in, lnk.line_pos_in,
                 lnk.tx_system_sync_in, lnk.tx_sync_pin, lnk.tx_system_data_in,
                 lnk.tx_data_in, lnk.tx_signaling_in, lnk.tx_link_data_in,
                 lnk.tx_backplane_clock, lnk.recovered_clock_in, lnk.tx_primary_clock};

  t1tx_fifo #(
    .WIDTH(`T1TX_ESTORE_WIDTH),
    .DEPTH(`T1TX_ESTORE_DEPTH)
  ) u_estore (
    .clk(clk),
    .rst_b(rst_b),
    .flush(ssync_edge),
    .in_valid(push),
    .in_ready(estore_in_ready),
    .in_data(push_bit),
    .out_valid(fifo_valid),
    .out_ready(f_rise),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    // two flops on every pin except line_iface_connect before anything looks at it
    n.meta = pins;
    n.sync = s.meta;
    // formatter clock is one of two sources, re-timed onto clk
    fclk = clock_source_recovered ? s.sync[`T1TX_IN_RCLK] : s.sync[`T1TX_IN_TX_PRIMARY_CLOCK];
    n.fclk_reg = fclk;
    f_rise = fclk & ~s.fclk_reg;
    f_fall = ~fclk & s.fclk_reg;
    b_fall = ~s.sync[`T1TX_IN_BCLK] & s.bclk_prev;
    n.bclk_prev = s.sync[`T1TX_IN_BCLK];
    n.sync_prev = s.sync[`T1TX_IN_SYNC];
    n.ssync_prev = s.sync[`T1TX_IN_SSYNC];
    sync_edge = s.sync[`T1TX_IN_SYNC] & ~s.sync_prev & ~sync_output_select;
    // system sync means nothing without the store, so it is ignored then
    ssync_edge = s.sync[`T1TX_IN_SSYNC] & ~s.ssync_prev & estore_enable;

    // store fill: backplane fall with store on, formatter fall otherwise
    push = estore_enable ? b_fall : f_fall;
    push_bit = s.sync[`T1TX_IN_SYSD];

    // signaling capture edge depends on the store
    if (estore_enable && b_fall) begin
      n.sig_bit = s.sync[`T1TX_IN_SIG];
    end
    sig_src = estore_enable ? s.sig_bit : s.sync[`T1TX_IN_SIG];

    // framing bit for the current frame when no link bit goes there
    if (frame_mode == T1TX_FM_D4) begin
      link_slot = s.frame_cnt[0];
      fbit = s.frame_cnt[0] ? FS_PAT[s.frame_cnt[3:1]] : ~s.frame_cnt[1];
    end else begin
      link_slot = (frame_mode == T1TX_FM_ESF) ? ~s.frame_cnt[0] : (s.frame_cnt[1:0] == 2'h0);
      fbit = s.frame_cnt[0] ?
             (s.frame_cnt[1] ? FPS_PAT[s.frame_cnt[4:2]] : 1'b0) : 1'b1;
    end

    // compose the outgoing bit at the falling transmit edge
    if (f_fall) begin
      if (s.bit_cnt == 8'h00) begin
        if (link_slot && link_insert_enable) begin
          n.tx_bit = s.sync[`T1TX_IN_LINK];
        end else begin
          n.tx_bit = fbit;
        end
      end else if (signaling_insert_enable && is_sig_frame(s.frame_cnt) &&
                   (s.bit_cnt[2:0] == 3'h0)) begin
        n.tx_bit = sig_src;
      end else begin
        n.tx_bit = s.sync[`T1TX_IN_DATA];
      end
    end

    // bit and frame position after the coming rising edge
    if (s.sync_req) begin
      nb = 8'h00;
      nf = (sync_multiframe_select || s.frame_cnt >= last_frame(frame_mode)) ?
           5'h00 : s.frame_cnt + 5'h01;
    end else if (s.bit_cnt == `T1TX_LAST_BIT) begin
      nb = 8'h00;
      nf = (s.frame_cnt >= last_frame(frame_mode)) ? 5'h00 : s.frame_cnt + 5'h01;
    end else begin
      nb = s.bit_cnt + 8'h01;
      nf = s.frame_cnt;
    end
    if (sync_multiframe_select) begin
      sync_hi = (nb == 8'h00) && (nf == 5'h00);
    end else begin
      sync_hi = (nb == 8'h00) ||
                (sync_double_wide_enable && nb == 8'h01 && is_sig_frame(nf));
    end

    // a sync arriving on the applying edge is kept for the next one
    n.sync_req = (s.sync_req & ~f_rise) | sync_edge;

    // everything that moves on the rising transmit edge
    if (f_rise) begin
      n.bit_cnt = nb;
      n.frame_cnt = nf;
      n.estore_out_reg = fifo_valid ? fifo_data : 1'b0;
      n.sync_out_reg = sync_output_select & sync_hi;
      if (output_nrz_select) begin
        n.pos_reg = s.tx_bit;
        n.neg_reg = 1'b0;
      end else if (s.tx_bit) begin
        // alternate mark inversion: each one flips rail
        n.pos_reg = ~s.ami_last;
        n.neg_reg = s.ami_last;
        n.ami_last = ~s.ami_last;
      end else begin
        n.pos_reg = 1'b0;
        n.neg_reg = 1'b0;
      end
    end
    // enable follows the select bit only; input mode never drives
    n.sync_oe_reg = sync_output_select;

    // line side: internal routing when the connect pin is high
    lclk = lnk.line_iface_connect ? s.fclk_reg : s.sync[`T1TX_IN_LCLK];
    n.lclk_prev = lclk;
    l_fall = ~lclk & s.lclk_prev;
    if (l_fall) begin
      n.line_pos_reg = lnk.line_iface_connect ? s.pos_reg : s.sync[`T1TX_IN_LPOS];
      n.line_neg_reg = lnk.line_iface_connect ? s.neg_reg : s.sync[`T1TX_IN_LNEG];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign lnk.tx_estore_data_out = s.estore_out_reg;
  assign lnk.dev_sync_out = s.sync_out_reg & s.sync_oe_reg;
  assign lnk.dev_sync_oe = s.sync_oe_reg;
  assign lnk.formatter_pos_out = s.pos_reg;
  assign lnk.formatter_neg_out = s.neg_reg;
  assign lnk.formatter_clock_out = s.fclk_reg;
  assign line_pos_out = s.line_pos_reg;
  assign line_neg_out = s.line_neg_reg;
endmodule : t1tx_device

// >>> src/t1tx_host.sv
// backplane end: makes the transmit clocks, feeds bits, wires the board
`timescale 1ns/1ps
`include "t1tx_cfg.svh"
module t1tx_host
  import t1tx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  t1tx_if.host lnk,
  input wire logic user_link_bit,
  input wire logic user_sig_bit,
  input wire logic user_data_bit,
  input wire logic estore_enable,
  input wire logic host_sync_drive,
  input wire logic nrz_tie,
  input wire logic connect_internal,
  output logic user_bit_taken
);
  localparam logic [3:0] PHALF = 4'(`T1TX_PRIMARY_HALF_CYC);
  localparam logic [3:0] BHALF = 4'(`T1TX_BACKPLANE_HALF_CYC);

  t1tx_host_state_t s;
  t1tx_host_state_t n;
  logic p_rise;
  logic b_rise;

  // ----------------------------------------------------------------
  // clock dividers and bit launch
  // ----------------------------------------------------------------
  // bits change on rising edges so the device samples mid-bit on falling
  always_comb begin
    n = s;
    n.taken = 1'b0;
    p_rise = 1'b0;
    b_rise = 1'b0;
    if (s.pdiv == PHALF - 4'h1) begin
      n.pdiv = 4'h0;
      n.pclk = ~s.pclk;
      p_rise = ~s.pclk;
    end else begin
      n.pdiv = s.pdiv + 4'h1;
    end
    // backplane clock only runs when the store is in use, else held low
    if (!estore_enable) begin
      n.bdiv = 4'h0;
      n.bclk = 1'b0;
    end else if (s.bdiv == BHALF - 4'h1) begin
      n.bdiv = 4'h0;
      n.bclk = ~s.bclk;
      b_rise = ~s.bclk;
    end else begin
      n.bdiv = s.bdiv + 4'h1;
    end
    if (p_rise) begin
      n.link = user_link_bit;
      n.bit_cnt = (s.bit_cnt == `T1TX_LAST_BIT) ? 8'h00 : s.bit_cnt + 8'h01;
      n.sync_pulse = host_sync_drive && (s.bit_cnt == `T1TX_LAST_BIT);
      n.taken = 1'b1;
    end
    if (estore_enable ? b_rise : p_rise) begin
      n.sig = user_sig_bit;
      n.sysdata = user_data_bit;
      // system sync stays low whenever the store is off
      n.ssync_pulse = estore_enable && (s.bit_cnt == `T1TX_LAST_BIT);
    end
    if (!estore_enable) begin
      n.ssync_pulse = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // pin drive and board wiring
  // ----------------------------------------------------------------
  assign lnk.tx_primary_clock = s.pclk;
  assign lnk.recovered_clock_in = s.pclk;
  assign lnk.tx_backplane_clock = s.bclk;
  assign lnk.tx_link_data_in = s.link;
  assign lnk.tx_signaling_in = s.sig;
  assign lnk.tx_system_data_in = s.sysdata;
  assign lnk.tx_system_sync_in = s.ssync_pulse;
  assign lnk.host_sync_out = s.sync_pulse;
  // enable follows host_sync_drive only; the device's own sync enable is not consulted
  assign lnk.host_sync_oe = host_sync_drive;
  assign lnk.tx_data_in = lnk.tx_estore_data_out;
  assign lnk.line_pos_in = lnk.formatter_pos_out;
  assign lnk.line_neg_in = nrz_tie ? lnk.formatter_pos_out : lnk.formatter_neg_out;
  assign lnk.line_clock_in = lnk.formatter_clock_out;
  assign lnk.line_iface_connect = connect_internal;
  assign user_bit_taken = s.taken;
endmodule : t1tx_host

// >>> sim/t1tx_assertions.sv
// concurrent checks on the t1 transmit pin bundle
`timescale 1ns/1ps
module t1tx_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tx_primary_clock,
  input wire logic tx_data_in,
  input wire logic tx_estore_data_out,
  input wire logic dev_sync_out,
  input wire logic formatter_pos_out,
  input wire logic formatter_neg_out,
  input wire logic formatter_clock_out
);
  // ----------
  // one domain
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // the selected clock shows three cycles after the pin, through the synchroniser
  AST_CLOCK_OUT: assert property (
    formatter_clock_out == $past(tx_primary_clock, 3)) else $error("clock out lags wrongly");
  AST_POS_EDGE: assert property (
    $changed(formatter_pos_out) |-> formatter_clock_out && !$past(formatter_clock_out))
    else $error("positive rail moved off the rising edge");
  AST_NEG_EDGE: assert property (
    $changed(formatter_neg_out) |-> formatter_clock_out && !$past(formatter_clock_out))
    else $error("negative rail moved off the rising edge");
  AST_ESTORE_EDGE: assert property (
    $changed(tx_estore_data_out) |-> formatter_clock_out && !$past(formatter_clock_out))
    else $error("store output moved off the rising edge");
  AST_SYNC_EDGE: assert property (
    $rose(dev_sync_out) |-> formatter_clock_out && !$past(formatter_clock_out))
    else $error("sync output rose off the rising edge");
  // both rails high would be a coding fault on the line
  AST_RAILS_EXCL: assert property (!(formatter_pos_out && formatter_neg_out))
    else $error("both rails high");
  AST_BOARD_TIE: assert property (tx_data_in == tx_estore_data_out)
    else $error("data input not tied to store output");
  AST_PRIMARY_HALF: assert property (
    $rose(tx_primary_clock) |-> tx_primary_clock [*6] ##1 !tx_primary_clock)
    else $error("primary clock half period wrong");
endmodule : t1tx_assertions

// >>> sim/transmit_side_pin_timing_bench.sv
// self-checking bench joining both ends of the t1 transmit pin block
`timescale 1ns/1ps
module transmit_side_pin_timing_bench;
  import t1tx_pkg::*;
  // ----------
  // stimulus and instances
  // ----------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic link_en = 1'b0, sync_sel = 1'b0, multi = 1'b0, dbl = 1'b0, nrz = 1'b0;
  logic est = 1'b0, sig_en = 1'b0, recov = 1'b0, u_link = 1'b0, u_sig = 1'b0;
  logic u_data = 1'b0, h_sync = 1'b0, tie = 1'b0, conn = 1'b0;
  logic est_ready, taken, line_pos, line_neg;
  t1tx_frame_mode_t mode = T1TX_FM_D4;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  t1tx_if lnk_if ();
  t1tx_device i_t1tx_device (.clk(clk), .rst_b(rst_b), .lnk(lnk_if),
    .link_insert_enable(link_en), .sync_output_select(sync_sel),
    .sync_multiframe_select(multi), .sync_double_wide_enable(dbl), .output_nrz_select(nrz),
    .estore_enable(est), .signaling_insert_enable(sig_en), .clock_source_recovered(recov),
    .frame_mode(mode), .line_pos_out(line_pos), .line_neg_out(line_neg),
    .estore_in_ready(est_ready));
  t1tx_host i_t1tx_host (.clk(clk), .rst_b(rst_b), .lnk(lnk_if), .user_link_bit(u_link),
    .user_sig_bit(u_sig), .user_data_bit(u_data), .estore_enable(est),
    .host_sync_drive(h_sync), .nrz_tie(tie), .connect_internal(conn), .user_bit_taken(taken));
  t1tx_assertions chk (.clk(clk), .rst_b(rst_b), .tx_primary_clock(lnk_if.tx_primary_clock),
    .tx_data_in(lnk_if.tx_data_in), .tx_estore_data_out(lnk_if.tx_estore_data_out),
    .dev_sync_out(lnk_if.dev_sync_out), .formatter_pos_out(lnk_if.formatter_pos_out),
    .formatter_neg_out(lnk_if.formatter_neg_out),
    .formatter_clock_out(lnk_if.formatter_clock_out));

  // ----------
  // compare and closing tasks
  // ----------
  task automatic check_bit(input string what, input logic exp, input logic seen);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask : check_bit

  task automatic check_range(input string what, input int lo, input int hi, input int seen);
    num_checks++;
    if (seen < lo || seen > hi) begin
      fail_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask : check_range

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // whole run is about 74k cycles, so this only trips on a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      conclude();
    end
  end

  // counts ones per bit period; windows of whole frames make the start point irrelevant
  task automatic count_win(input int settle, input int bits, output int p, output int n,
                           output int s, output int lp, output int ln);
    logic prev;
    int k;
    prev = 1'b1;
    k = 0;
    {p, n, s, lp, ln} = '0;
    while (k < settle + bits) begin
      @(negedge clk);
      if (lnk_if.formatter_clock_out === 1'b1 && prev === 1'b0) begin
        if (k >= settle) begin
          // an unknown rail must not slip through as a zero
          if ($isunknown({lnk_if.formatter_pos_out, lnk_if.formatter_neg_out,
                          line_pos, line_neg})) begin
            p += 1000;
          end
          p += lnk_if.formatter_pos_out;
          n += lnk_if.formatter_neg_out;
          s += lnk_if.tx_sync_pin;
          lp += line_pos;
          ln += line_neg;
        end
        k++;
      end
      prev = lnk_if.formatter_clock_out;
    end
  endtask : count_win

  // ----------
  // scenarios
  // ----------
  task automatic scen_reset;
    check_bit("sync drive after reset", 1'b0, lnk_if.dev_sync_oe);
    check_bit("positive rail after reset", 1'b0, lnk_if.formatter_pos_out);
  endtask : scen_reset

  // store on: backplane outpaces the formatter, so the store fills until system sync flushes it
  task automatic scen_fifo;
    logic full, stored;
    int k, run, best;
    full = 1'b0;
    stored = 1'b0;
    k = 0;
    run = 0;
    best = 0;
    @(posedge clk);
    est <= 1'b1;
    u_data <= 1'b1;
    while (full !== 1'b1 && k < 2400) begin
      @(negedge clk);
      full = (est_ready === 1'b0);
      stored = lnk_if.tx_estore_data_out;
      k++;
    end
    check_bit("fifo fill", 1'b1, full);
    check_bit("store output", 1'b1, stored);
    // without a flush a pop is refilled within one backplane period
    repeat (2600) begin
      @(negedge clk);
      run = (est_ready === 1'b1) ? run + 1 : 0;
      best = (run > best) ? run : best;
    end
    check_range("fifo flush run", 100, 2600, best);
    @(posedge clk);
    est <= 1'b0;
    u_data <= 1'b0;
  endtask : scen_fifo

  task automatic scen_rails;
    int p, n, s, lp, ln;
    @(posedge clk) u_data <= 1'b1;
    count_win(100, 193, p, n, s, lp, ln);
    check_range("ami ones", 192, 193, p + n);
    check_range("ami positive", 96, 97, p);
    @(posedge clk) nrz <= 1'b1;
    count_win(100, 193, p, n, s, lp, ln);
    check_range("nrz ones", 192, 193, p);
    @(posedge clk) u_data <= 1'b0;
    count_win(100, 193, p, n, s, lp, ln);
    check_range("zero data ones", 0, 1, p);
  endtask : scen_rails

  // one multiframe each: link in fs slots, then signaling with sync per multiframe
  task automatic scen_frames;
    int p, n, s, lp, ln;
    @(posedge clk);
    link_en <= 1'b1;
    u_link <= 1'b1;
    sync_sel <= 1'b1;
    dbl <= 1'b1;
    conn <= 1'b1;
    count_win(100, 2316, p, n, s, lp, ln);
    check_range("link frame ones", 9, 9, p);
    check_range("double sync bits", 14, 14, s);
    check_range("internal line ones", 9, 9, lp);
    check_range("internal line negative", 0, 0, ln);
    @(posedge clk);
    link_en <= 1'b0;
    sig_en <= 1'b1;
    u_sig <= 1'b1;
    multi <= 1'b1;
    conn <= 1'b0;
    tie <= 1'b1;
    recov <= 1'b1;
    count_win(100, 2316, p, n, s, lp, ln);
    check_range("signaling ones", 54, 54, p);
    check_range("multiframe sync bits", 1, 1, s);
    check_range("external line ones", 54, 54, lp);
    check_range("tied line negative", 54, 54, ln);
  endtask : scen_frames

  task automatic scen_sync_in;
    logic seen, oe;
    int tk;
    seen = 1'b0;
    oe = 1'b0;
    tk = 0;
    @(posedge clk) sync_sel <= 1'b0;
    repeat (4) @(posedge clk);
    h_sync <= 1'b1;
    repeat (2400) begin
      @(negedge clk);
      seen |= lnk_if.tx_sync_pin;
      oe |= lnk_if.dev_sync_oe;
      tk += (taken === 1'b1) ? 1 : 0;
    end
    check_bit("host sync seen", 1'b1, seen);
    check_range("bit launches", 199, 201, tk);
    check_bit("device sync drive", 1'b0, oe);
    @(posedge clk) h_sync <= 1'b0;
  endtask : scen_sync_in

  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    scen_reset();
    scen_fifo();
    scen_rails();
    scen_frames();
    scen_sync_in();
    conclude();
  end
endmodule : transmit_side_pin_timing_bench
